// [asc_sequencer.sv]
/*
 * Converter sequencer control: control/status and trigger registers,
 * single and scan sequencing, trigger selection, result routing and
 * the conversion-end request.
 * Assumes an 8-bit internal bus on the system clock, a front end that
 * presents the current channel's value on CONV_DATA_I at conversion
 * end, and standby/module-stop levels from the system controller.
 */
// Behaviour
// - eight inputs, channels 0-3 form group 0 and 4-7 form group 1
// - dedicated external trigger pin can start conversion when selected
// - four 16-bit result registers, read only to software
// - ten result bits sit in bits 15..6, low six bits read zero
// - high-byte read returns directly and latches low byte for later read
// - channels n and n+4 both land in result register n
// - end flag sets after a single conversion or a full scan pass
// - end flag clears by writing 0 after reading 1; writing 1 does nothing
// - transfer controller reading a result register clears end flag
// - conversion-end request is flag and enable together
// - writing start begins conversion; single mode clears start at end
// - scan repeats until start cleared by software, reset or low power
// - flag, enable, start and scan bits are zero after reset
// - mode bit 0 single, 1 scan; change only while stopped
// - 3-bit channel field: one channel, or group base up to field
// - trigger select 00 none, 10 timer, 11 pin, 01 prohibited
// - clock-select picks 266 or 134 states per channel
`timescale 1ns/10ps
`default_nettype none
module asc_sequencer
    import asc_pkg::*;
(
    input  wire logic                SYS_CLK_I,
    input  wire logic                RST_I,
    input  wire logic [3:0]          BUS_ADDR_I,
    input  wire logic                BUS_RD_I,
    input  wire logic                BUS_WR_I,
    input  wire logic [7:0]          BUS_WDATA_I,
    input  wire logic                XFER_READ_I,
    input  wire logic                TIMER_TRIG_I,
    input  wire logic                EXT_CONV_TRIGGER_I,
    input  wire logic                STANDBY_I,
    input  wire logic                MODULE_STOP_I,
    input  wire logic [RES_BITS-1:0] CONV_DATA_I,
    output logic      [7:0]          BUS_RDATA_O,
    output logic      [2:0]          CONV_CHAN_O,
    output logic                     CONV_BUSY_O,
    output logic                     CONV_END_IRQ_O
);
    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic       conv_end_flag;
    logic       conv_irq_enable;
    logic       conv_start_bit;
    logic       scan_mode;
    logic       conv_time_sel;
    logic [2:0] chan_sel;
    logic [1:0] trig_sel;
    logic [5:0] trig_rsv;
    logic       flag_armed;
    logic [2:0] cur_chan;
    logic [7:0] rdata;
    logic       ext_meta;
    logic       ext_sync;
    logic       ext_prev;
    asc_state_e state;
    asc_state_e next_state;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire csr_sel  = (BUS_ADDR_I == ADDR_CSR);
    wire trig_hit = (BUS_ADDR_I == ADDR_TRIG);
    wire res_sel  = (BUS_ADDR_I <= ADDR_RES_D_LO);
    wire csr_wr   = BUS_WR_I & csr_sel;
    wire csr_rd   = BUS_RD_I & csr_sel;
    wire trig_wr  = BUS_WR_I & trig_hit;
    wire res_rd   = BUS_RD_I & res_sel;
    wire rd_hi    = res_rd & ~BUS_ADDR_I[0];
    wire [7:0] res_hi;
    wire [7:0] res_lo;
    wire [7:0] csr_val = {conv_end_flag, conv_irq_enable, conv_start_bit,
                          scan_mode, conv_time_sel, chan_sel};
    // result writes from the bus fall through: no write path exists
    wire [7:0] next_rdata = !BUS_RD_I ? rdata :
                            res_rd    ? (BUS_ADDR_I[0] ? res_lo : res_hi) :
                            csr_sel   ? csr_val :
                            trig_hit  ? {trig_sel, trig_rsv} :
                                        UNMAPPED_RD;

    // ------------------------------------------------------------------
    // triggers and low power
    // ------------------------------------------------------------------
    // standby and module stop come from the system controller's clock
    wire low_power = STANDBY_I | MODULE_STOP_I;
    wire ext_fall  = ext_prev & ~ext_sync;
    // the prohibited code 01 is treated like 00: no hardware start
    wire hw_trig   = ((trig_sel == TRG_TIMER) & TIMER_TRIG_I) |
                     ((trig_sel == TRG_EXT) & ext_fall);

    // ------------------------------------------------------------------
    // sequencing terms
    // ------------------------------------------------------------------
    wire [2:0] group_base = {chan_sel[2], 2'b00};
    wire       last_chan  = (cur_chan == chan_sel);
    wire       abort      = ~conv_start_bit | low_power;
    wire       tmr_done;
    wire       res_we     = (state == ST_CONV) & tmr_done & ~abort;
    wire       set_flag   = (state == ST_POST) & (~scan_mode | last_chan);
    wire       single_end = (state == ST_POST) & ~scan_mode;

    // ------------------------------------------------------------------
    // control/status next values
    // ------------------------------------------------------------------
    wire sw_clr    = csr_wr & ~BUS_WDATA_I[CSR_FLAG_BIT] & flag_armed;
    wire xfer_clr  = res_rd & XFER_READ_I;
    // a set in the same cycle as a clear wins
    wire next_flag = set_flag |
                     (conv_end_flag & ~sw_clr & ~xfer_clr);
    wire next_armed = (csr_rd & conv_end_flag) | (flag_armed & ~csr_wr);
    wire start_set  = hw_trig | (csr_wr & BUS_WDATA_I[CSR_START_BIT]);
    wire next_start = start_set |
                      (conv_start_bit & ~csr_wr & ~single_end);
    wire cont       = scan_mode & next_start & ~low_power;
    wire tmr_start  = ((state == ST_IDLE) & conv_start_bit & ~low_power) |
                      ((state == ST_POST) & cont);
    wire tmr_abort  = (state == ST_CONV) & abort;
    wire [2:0] next_chan =
        (state == ST_IDLE) ? (scan_mode ? group_base : chan_sel) :
        last_chan          ? group_base :
                             cur_chan + 3'h1;

    // ------------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (tmr_start) next_state = ST_CONV;
            ST_CONV: begin
                if (abort) next_state = ST_IDLE;
                else if (tmr_done) next_state = ST_POST;
            end
            ST_POST: next_state = cont ? ST_CONV : ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    asc_conv_timer u_timer (
        .clk_i   (SYS_CLK_I),
        .rst_i   (RST_I),
        .start_i (tmr_start),
        .abort_i (tmr_abort),
        .fast_i  (conv_time_sel),
        .done_o  (tmr_done)
    );

    asc_result_file #(.NUM(4)) u_results (
        .clk_i   (SYS_CLK_I),
        .rst_i   (RST_I),
        .we_i    (res_we),
        .widx_i  (cur_chan[1:0]),
        .wdata_i (CONV_DATA_I),
        .rd_hi_i (rd_hi),
        .ridx_i  (BUS_ADDR_I[2:1]),
        .hi_o    (res_hi),
        .lo_o    (res_lo)
    );

    // ------------------------------------------------------------------
    // external trigger synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
            ext_prev <= 1'b1;
        end else begin
            ext_meta <= EXT_CONV_TRIGGER_I;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // ------------------------------------------------------------------
    // control/status register
    // ------------------------------------------------------------------
    // low power clears the whole register just as reset does
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            {conv_end_flag, conv_irq_enable, conv_start_bit,
             scan_mode, conv_time_sel, chan_sel} <= CSR_RESET;
            flag_armed <= 1'b0;
        end else if (low_power) begin
            {conv_end_flag, conv_irq_enable, conv_start_bit,
             scan_mode, conv_time_sel, chan_sel} <= CSR_RESET;
            flag_armed <= 1'b0;
        end else begin
            conv_end_flag  <= next_flag;
            conv_start_bit <= next_start;
            flag_armed     <= next_armed;
            if (csr_wr) begin
                conv_irq_enable <= BUS_WDATA_I[CSR_IE_BIT];
                scan_mode       <= BUS_WDATA_I[CSR_SCAN_BIT];
                conv_time_sel   <= BUS_WDATA_I[CSR_CKS_BIT];
                chan_sel        <= BUS_WDATA_I[2:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // trigger control, sequencer state and read data
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            {trig_sel, trig_rsv} <= TRIG_RESET;
            state    <= ST_IDLE;
            cur_chan <= 3'h0;
            rdata    <= 8'h00;
        end else begin
            if (trig_wr) begin
                {trig_sel, trig_rsv} <= BUS_WDATA_I;
            end
            state <= low_power ? ST_IDLE : next_state;
            if (tmr_start) begin
                cur_chan <= next_chan;
            end
            rdata <= next_rdata;
        end
    end

    assign BUS_RDATA_O    = rdata;
    assign CONV_CHAN_O    = cur_chan;
    assign CONV_BUSY_O    = (state == ST_CONV);
    assign CONV_END_IRQ_O = conv_end_flag & conv_irq_enable;

    // ------------------------------------------------------------------
    // check helpers
    // ------------------------------------------------------------------
    // cycles spent in the running conversion; counted apart from the
    // timer so the timing check does not lean on the timer's own count
    localparam logic [8:0] SLOW_LAST = 9'(CONV_CYC_SLOW - 1);
    localparam logic [8:0] FAST_LAST = 9'(CONV_CYC_FAST - 1);
    logic [8:0] conv_age;
    wire  [8:0] conv_last = conv_time_sel ? FAST_LAST : SLOW_LAST;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            conv_age <= 9'h000;
        end else begin
            conv_age <= CONV_BUSY_O ? conv_age + 9'h001 : 9'h000;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_irq_gate : assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(conv_end_flag) && conv_irq_enable |-> CONV_END_IRQ_O
    ) else $error("end request missing while enabled");

    a_result_first : assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(conv_end_flag) |-> $past(res_we, 2)
    ) else $error("end flag rose without a fresh result");

    a_single_stop : assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (state == ST_POST) && !scan_mode && !start_set |=>
            !conv_start_bit && (state == ST_IDLE)
    ) else $error("single mode did not clear start");

    a_scan_keeps : assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (state == ST_POST) && scan_mode && conv_start_bit && !csr_wr &&
            !low_power |=> conv_start_bit && (state == ST_CONV)
    ) else $error("scan stopped on its own");

    a_write_one : assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        !conv_end_flag && csr_wr && BUS_WDATA_I[CSR_FLAG_BIT] &&
            !set_flag |=> !conv_end_flag
    ) else $error("writing one set the end flag");

    a_low_zero : assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        res_rd && BUS_ADDR_I[0] |=> BUS_RDATA_O[5:0] == 6'h00
    ) else $error("result pad bits not zero");

    a_scan_range : assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        CONV_BUSY_O && scan_mode |->
            cur_chan >= group_base && cur_chan <= chan_sel
    ) else $error("scan channel outside selected range");

    a_conv_slow : assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        CONV_BUSY_O |-> (conv_age < conv_last && !tmr_done) ||
            (conv_age == conv_last && tmr_done)
    ) else $error("conversion time wrong");

    a_ext_start : assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        ext_fall && trig_sel == TRG_EXT && !low_power |=> conv_start_bit
    ) else $error("pin trigger did not start conversion");

endmodule
`default_nettype wire

// [asc_pkg.sv]
/*
 * Shared constants for the converter sequencer control: internal bus
 * offsets, control/status field positions, reset values, trigger
 * encodings and conversion timing.
 * Assumes an 8-bit internal register bus with a byte address.
 */
`default_nettype none
package asc_pkg;

    // --------------------------------------------------------------
    // internal bus byte offsets
    // --------------------------------------------------------------
    localparam logic [3:0] ADDR_RES_A_HI = 4'h0;
    localparam logic [3:0] ADDR_RES_A_LO = 4'h1;
    localparam logic [3:0] ADDR_RES_B_HI = 4'h2;
    localparam logic [3:0] ADDR_RES_B_LO = 4'h3;
    localparam logic [3:0] ADDR_RES_C_HI = 4'h4;
    localparam logic [3:0] ADDR_RES_C_LO = 4'h5;
    localparam logic [3:0] ADDR_RES_D_HI = 4'h6;
    localparam logic [3:0] ADDR_RES_D_LO = 4'h7;
    localparam logic [3:0] ADDR_CSR      = 4'h8;
    localparam logic [3:0] ADDR_TRIG     = 4'h9;

    // --------------------------------------------------------------
    // control/status and trigger control fields
    // --------------------------------------------------------------
    localparam int CSR_FLAG_BIT  = 7;
    localparam int CSR_IE_BIT    = 6;
    localparam int CSR_START_BIT = 5;
    localparam int CSR_SCAN_BIT  = 4;
    localparam int CSR_CKS_BIT   = 3;
    localparam int TRIG_SEL_LSB  = 6;
    localparam logic [7:0] CSR_RESET   = 8'h00;
    localparam logic [7:0] TRIG_RESET  = 8'h3f;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    localparam logic [1:0] TRG_NONE    = 2'h0;
    localparam logic [1:0] TRG_TIMER   = 2'h2;
    localparam logic [1:0] TRG_EXT     = 2'h3;

    // --------------------------------------------------------------
    // result layout and conversion timing
    // --------------------------------------------------------------
    localparam int RES_BITS   = 10;
    localparam int RES_PAD    = 6;
    localparam logic [15:0] RES_RESET = 16'h0000;
    localparam int STATE_CYCLES     = 1;   // one state is one clock
    localparam int CONV_STATES_SLOW = 266;
    localparam int CONV_STATES_FAST = 134;
    localparam int CONV_CYC_SLOW    = CONV_STATES_SLOW * STATE_CYCLES;
    localparam int CONV_CYC_FAST    = CONV_STATES_FAST * STATE_CYCLES;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_POST
    } asc_state_e;

endpackage
`default_nettype wire

// [asc_conv_timer.sv]
/*
 * Per-channel conversion timer: counts the conversion time chosen by
 * the clock-select bit and pulses done at its end.
 * Assumes start and abort come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module asc_conv_timer
    import asc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic abort_i,
    input  wire logic fast_i,
    output logic      done_o
);
    localparam logic [8:0] LOAD_SLOW = 9'(CONV_CYC_SLOW - 1);
    localparam logic [8:0] LOAD_FAST = 9'(CONV_CYC_FAST - 1);

    logic [8:0] cnt;
    logic       run;
    wire  [8:0] load_val = fast_i ? LOAD_FAST : LOAD_SLOW;
    wire        at_end   = run & (cnt == 9'h000);

    // ------------------------------------------------------------------
    // countdown
    // ------------------------------------------------------------------
    // done comes from the counter itself so it never leads the count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 9'h000;
            run <= 1'b0;
        end else if (start_i) begin
            cnt <= load_val;
            run <= 1'b1;
        end else if (abort_i | at_end) begin
            run <= 1'b0;
        end else if (run) begin
            cnt <= cnt - 9'h001;
        end
    end

    assign done_o = at_end & ~abort_i;

endmodule
`default_nettype wire

// [asc_result_file.sv]
/*
 * Result store: four read-only result words with byte readout through
 * a temporary latch for the low byte.
 * Assumes the owner decodes the bus and writes one entry at a time.
 */
`timescale 1ns/10ps
`default_nettype none
module asc_result_file
    import asc_pkg::*;
#(
    parameter int NUM = 4
)(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                we_i,
    input  wire logic [1:0]          widx_i,
    input  wire logic [RES_BITS-1:0] wdata_i,
    input  wire logic                rd_hi_i,
    input  wire logic [1:0]          ridx_i,
    output logic      [7:0]          hi_o,
    output logic      [7:0]          lo_o
);
    logic [15:0] res [NUM];
    logic [7:0]  tmp;

    // ------------------------------------------------------------------
    // result words, left aligned with zero pad
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM; i++) begin : g_res
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                res[i] <= RES_RESET;
            end else if (we_i && (widx_i == 2'(i))) begin
                res[i] <= {wdata_i, {RES_PAD{1'b0}}};
            end
        end
    end

    // low byte is frozen at the high-byte read so both halves match
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmp <= 8'h00;
        end else if (rd_hi_i) begin
            tmp <= res[ridx_i][7:0];
        end
    end

    assign hi_o = res[ridx_i][15:8];
    assign lo_o = tmp;

endmodule
`default_nettype wire

// [asc_front_model.sv]
/*
 * Far-side model for the converter sequencer: eight analog inputs that
 * give a distinct value per channel, plus the timer trigger and the
 * external trigger pin.
 * Assumes the bench calls its tasks from one thread at a time.
 */
`timescale 1ns/10ps
`default_nettype none
module asc_front_model
    import asc_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic [2:0]          chan_i,
    input  wire logic                busy_i,
    output logic      [RES_BITS-1:0] data_o,
    output logic                     timer_trig_o,
    output logic                     ext_trig_o
);
    // ----------------------------------------------------------
    // analog inputs
    // ----------------------------------------------------------
    // channel number in the top bits so k and k+4 differ
    function automatic logic [RES_BITS-1:0] level(input logic [2:0] ch);
        level = {ch, 7'h2a};
    endfunction

    // outside a conversion the value is inverted, never held
    assign data_o = busy_i ? level(chan_i) : ~level(chan_i);

    // ----------------------------------------------------------
    // trigger sources, changed at the falling edge
    // ----------------------------------------------------------
    initial begin
        timer_trig_o = 1'b0;
        ext_trig_o   = 1'b1;
    end

    task automatic fire_timer();
        @(negedge clk_i);
        timer_trig_o = 1'b1;
        @(negedge clk_i);
        timer_trig_o = 1'b0;
    endtask

    // pin idles high; held low long enough for the synchroniser
    task automatic fire_ext();
        @(negedge clk_i);
        ext_trig_o = 1'b0;
        repeat (4) @(negedge clk_i);
        ext_trig_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// [asc_sequencer_tb_top.sv]
/*
 * Self-checking bench for the converter sequencer: register reset
 * values, byte readout, single and scan runs, triggers, flag clearing.
 * Assumes the front-end model above and a 20 MHz system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module asc_sequencer_tb_top;
    import asc_pkg::*;

    logic                clk, rst, rd, wr, xfer, standby, mstop;
    logic [3:0]          addr;
    logic [7:0]          wdata, v;
    wire logic [7:0]     rdata;
    wire logic [2:0]     chan;
    wire logic           busy, irq, ttrig, etrig;
    wire logic [RES_BITS-1:0] cdata;
    int                  n_fail, cmp_count, cyc, i;

    always #25 clk = ~clk;

    asc_sequencer i_asc_sequencer (
        .SYS_CLK_I(clk), .RST_I(rst), .BUS_ADDR_I(addr), .BUS_RD_I(rd),
        .BUS_WR_I(wr), .BUS_WDATA_I(wdata), .XFER_READ_I(xfer),
        .TIMER_TRIG_I(ttrig), .EXT_CONV_TRIGGER_I(etrig),
        .STANDBY_I(standby), .MODULE_STOP_I(mstop), .CONV_DATA_I(cdata),
        .BUS_RDATA_O(rdata), .CONV_CHAN_O(chan), .CONV_BUSY_O(busy),
        .CONV_END_IRQ_O(irq));

    asc_front_model i_asc_front_model (
        .clk_i(clk), .chan_i(chan), .busy_i(busy), .data_o(cdata),
        .timer_trig_o(ttrig), .ext_trig_o(etrig));

    // ----------------------------------------------------------
    // reporting and bus tasks
    // ----------------------------------------------------------
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // strobe for one cycle; data is registered, so taken a cycle later
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd   = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d  = rdata;
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bus_rd(a, d);
        check({8'h00, d}, {8'h00, exp});
    endtask

    // high byte first, then low byte from the latch
    task automatic res_chk(input int idx, input logic [2:0] ch);
        logic [15:0] w;
        w = {ch, 7'h2a, 6'h00};
        rd_chk(4'(2 * idx), w[15:8]);
        rd_chk(4'(2 * idx + 1), w[7:0]);
    endtask

    // counts rising edges until the request shows; a must-wait that
    // runs out ends the run
    task automatic wait_irq(input int lim, input logic must);
        cyc = 0;
        while (irq !== 1'b1 && cyc < lim) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        if (must && irq !== 1'b1) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, irq, 1'b1);
            complete_run();
        end
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        clk = 1'b0; rst = 1'b1; rd = 1'b0; wr = 1'b0; xfer = 1'b0;
        standby = 1'b0; mstop = 1'b0; addr = 4'h0; wdata = 8'h00;
        n_fail = 0; cmp_count = 0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        // reset values, read-only results, unmapped space
        rd_chk(ADDR_CSR, CSR_RESET);
        rd_chk(ADDR_TRIG, TRIG_RESET);
        for (i = 0; i < 8; i++) rd_chk(4'(i), 8'h00);
        rd_chk(4'ha, UNMAPPED_RD);
        bus_wr(ADDR_RES_A_HI, 8'hff);
        rd_chk(ADDR_RES_A_HI, 8'h00);
        // single channel 5, fast timing: flag lands 136 edges on
        bus_wr(ADDR_CSR, 8'h6d);
        wait_irq(400, 1'b1);
        check(16'(cyc), 16'd136);
        rd_chk(ADDR_CSR, 8'hcd);
        res_chk(1, 3'd5);
        // low-byte read returns the latch of the last high read
        bus_rd(ADDR_RES_B_HI, v);
        bus_rd(ADDR_RES_A_HI, v);
        rd_chk(ADDR_RES_B_LO, 8'h00);
        // writing 1 keeps the flag; clearing needs a prior read
        bus_wr(ADDR_CSR, 8'hc5);
        bus_wr(ADDR_CSR, 8'h45);
        rd_chk(ADDR_CSR, 8'hc5);
        bus_wr(ADDR_CSR, 8'h45);
        rd_chk(ADDR_CSR, 8'h45);
        check({15'h0, irq}, 16'h0000);
        // same channel at slow timing: flag lands 268 edges on
        bus_wr(ADDR_CSR, 8'h65);
        wait_irq(400, 1'b1);
        check(16'(cyc), 16'd268);
        rd_chk(ADDR_CSR, 8'hc5);
        bus_wr(ADDR_CSR, 8'h45);
        // scan group 0, channels 0 to 3
        bus_wr(ADDR_CSR, 8'h7b);
        wait_irq(800, 1'b1);
        rd_chk(ADDR_CSR, 8'hfb);
        for (i = 0; i < 4; i++) res_chk(i, 3'(i));
        bus_wr(ADDR_CSR, 8'h0b);
        // the abort lands one edge after the write
        @(negedge clk);
        check({15'h0, busy}, 16'h0000);
        rd_chk(ADDR_CSR, 8'h0b);
        // scan group 1 up to channel 5 leaves register c alone
        bus_wr(ADDR_CSR, 8'h7d);
        wait_irq(500, 1'b1);
        rd_chk(ADDR_CSR, 8'hfd);
        bus_wr(ADDR_CSR, 8'h0d);
        res_chk(0, 3'd4);
        res_chk(1, 3'd5);
        res_chk(2, 3'd2);
        // every trigger select code, both sources fired each time
        for (i = 0; i < 4; i++) begin
            bus_wr(ADDR_TRIG, {2'(i), 6'h3f});
            bus_wr(ADDR_CSR, 8'h4c + 8'(i));
            i_asc_front_model.fire_timer();
            i_asc_front_model.fire_ext();
            wait_irq(400, 1'(i >> 1));
            check({15'h0, irq}, 16'(i >> 1));
            if (i >= 2) begin
                @(negedge clk);
                xfer = 1'b1;
                bus_rd(4'(2 * i), v);
                xfer = 1'b0;
                rd_chk(ADDR_CSR, 8'h4c + 8'(i));
                res_chk(i, 3'(4 + i));
            end
        end
        // standby then module stop abort a running scan
        for (i = 0; i < 2; i++) begin
            bus_wr(ADDR_CSR, 8'h7b);
            repeat (3) @(negedge clk);
            standby = (i == 0);
            mstop   = (i == 1);
            repeat (2) @(negedge clk);
            check({15'h0, busy}, 16'h0000);
            standby = 1'b0;
            mstop   = 1'b0;
            rd_chk(ADDR_CSR, CSR_RESET);
            rd_chk(ADDR_TRIG, 8'hff);
        end
        complete_run();
    end
endmodule
`default_nettype wire
